//--- sep_pkg.sv
/*
  Constants, state types and carrier structs of the serial EEPROM bus pin
  interface. Assumes a 100 MHz core clock sampling the two-wire bus pins.
*/
package sep_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS   = 10;
  localparam int GF_NS    = 50;       // glitch_filter_width
  localparam int HOLD_NS  = 300;
  localparam int TWC_MS   = 5;
  localparam int GF_CYC   = (GF_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWC_CYC  = (TWC_MS * 1000000) / CLK_NS;

  // ----------------------------------------------------------------
  // Layout
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_CODE  = 4'ha;
  localparam int         AW         = 12;
  localparam int         PAGE_BYTES = 32;
  localparam logic [3:0] BITS_BYTE  = 4'h8;
  localparam int         WC_W       = 20;
  localparam int         FC_W       = 3;
  localparam int         HC_W       = 5;
  localparam int         I_SCL      = 0;
  localparam int         I_SDA      = 1;
  localparam int         I_WP       = 2;
  localparam int         I_CS       = 3;

  localparam logic [1:0] K_CTRL = 2'h0;
  localparam logic [1:0] K_AHI  = 2'h1;
  localparam logic [1:0] K_ALO  = 2'h2;
  localparam logic [1:0] K_DATA = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } sep_st_e;

  typedef struct packed {
    logic          we;
    logic [AW-1:0] addr;
    logic [7:0]    data;
  } sep_wr_s;

  typedef struct packed {
    logic [5:0]                 sy1;
    logic [5:0]                 sy2;
    logic [1:0]                 flt;
    logic [1:0]                 flt_p;
    logic [1:0][FC_W-1:0]       fcnt;
    sep_st_e                    st;
    logic [1:0]                 kind;
    logic [3:0]                 bits;
    logic [7:0]                 sh;
    logic                       rd;
    logic [AW-1:0]              ptr;
    logic [6:0]                 page;
    logic [PAGE_BYTES-1:0]      vmask;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic                       pend;
    logic                       busy;
    logic [WC_W-1:0]            wc;
    logic                       want;
    logic                       oe;
    logic [HC_W-1:0]            hold;
  } sep_state_s;

endpackage : sep_pkg

//--- sep_mem.sv
/*
  Byte-wide array of the EEPROM with one write port and one registered
  read port. Assumes writes come from the self-timed write cycle only.
*/
`timescale 1ns/1ns
`default_nettype none
module sep_mem
  import sep_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire sep_wr_s       wr_in,
  input  wire logic [AW-1:0] raddr_in,
  output var  logic [7:0]    rdata_out
);

  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_in)
  begin
    if (wr_in.we)
    begin
      mem[wr_in.addr] <= wr_in.data;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_out <= 8'h00;
    end
    else
    begin
      rdata_out <= mem[raddr_in];
    end
  end

endmodule : sep_mem
`default_nettype wire

//--- sep_top.sv
/*
  Pin-level slave of a two-wire serial EEPROM: pin synchronisers, spike
  filters, start/stop detection, address match, byte transfer, page buffer
  and self-timed write cycle. Assumes an external pull-up on the data wire
  and a bus clock far slower than clk_in.
*/
`timescale 1ns/1ns
`default_nettype none
module sep_top
  import sep_pkg::*;
#(
  parameter int WRITE_CYCLES = TWC_CYC
)
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic chip_select_strap_0_in,
  input  wire logic chip_select_strap_1_in,
  input  wire logic chip_select_strap_2_in,
  input  wire logic write_protect_in,
  output var  logic sda_out,
  output var  logic sda_oe_out,
  output var  logic write_busy_out
);

  sep_state_s    s_q;
  sep_state_s    s_d;
  sep_wr_s       wr;
  logic [7:0]    rdata;
  logic          rise;
  logic          fall;
  logic          start;
  logic          stop;
  logic          match;
  logic [2:0]    straps;
  logic [AW-1:0] lo_ptr;

  // ----------------------------------------------------------------
  // Array and write-cycle port
  // ----------------------------------------------------------------
  always_comb
  begin
    wr.we   = s_q.busy && (s_q.wc < WC_W'(PAGE_BYTES))
              && s_q.vmask[s_q.wc[4:0]];
    wr.addr = {s_q.page, s_q.wc[4:0]};
    wr.data = s_q.pbuf[s_q.wc[4:0]];
  end

  sep_mem u_mem (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .wr_in     (wr),
    .raddr_in  (s_q.ptr),
    .rdata_out (rdata)
  );

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  assign straps = s_q.sy2[I_CS +: 3];
  assign rise   = s_q.flt[I_SCL] & ~s_q.flt_p[I_SCL];
  assign fall   = ~s_q.flt[I_SCL] & s_q.flt_p[I_SCL];
  assign start  = s_q.flt[I_SCL] & s_q.flt_p[I_SCL]
                  & s_q.flt_p[I_SDA] & ~s_q.flt[I_SDA];
  assign stop   = s_q.flt[I_SCL] & s_q.flt_p[I_SCL]
                  & ~s_q.flt_p[I_SDA] & s_q.flt[I_SDA];
  assign match  = (s_q.sh[7:4] == CTRL_CODE)
                  && (s_q.sh[3:1] == straps);
  assign lo_ptr = {s_q.ptr[AW-1:8], s_q.sh};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d       = s_q;
    s_d.sy1   = {straps_raw(), write_protect_in, sda_in, scl_in};
    s_d.sy2   = s_q.sy1;
    s_d.flt_p = s_q.flt;
    for (int i = 0; i < 2; i++)
    begin
      if (s_q.sy2[i] == s_q.flt[i])
      begin
        s_d.fcnt[i] = '0;
      end
      else if (s_q.fcnt[i] == FC_W'(GF_CYC))
      begin
        s_d.flt[i]  = s_q.sy2[i];
        s_d.fcnt[i] = '0;
      end
      else
      begin
        s_d.fcnt[i] = s_q.fcnt[i] + FC_W'(1);
      end
    end

    if (s_q.busy)
    begin
      s_d.wc = s_q.wc + WC_W'(1);
      if (s_q.wc == WC_W'(WRITE_CYCLES - 1))
      begin
        s_d.busy = 1'b0;
      end
    end

    if (start)
    begin
      s_d.st   = ST_RX;
      s_d.kind = K_CTRL;
      s_d.bits = '0;
      s_d.want = 1'b0;
      s_d.pend = 1'b0;
    end
    else if (stop)
    begin
      s_d.st   = ST_IDLE;
      s_d.want = 1'b0;
      if (s_q.pend && !s_q.busy && !s_q.sy2[I_WP])
      begin
        s_d.busy = 1'b1;
        s_d.wc   = '0;
      end
      s_d.pend = 1'b0;
    end
    else
    begin
      unique case (s_q.st)
        ST_IDLE:
        begin
        end
        ST_RX:
        begin
          if (rise && s_q.bits != BITS_BYTE)
          begin
            s_d.sh   = {s_q.sh[6:0], s_q.flt[I_SDA]};
            s_d.bits = s_q.bits + 4'h1;
          end
          else if (fall && s_q.bits == BITS_BYTE)
          begin
            s_d.st   = ST_ACK;
            s_d.want = ~s_q.busy;
            unique case (s_q.kind)
              K_CTRL:
              begin
                s_d.rd = s_q.sh[0];
                if (!match || s_q.busy)
                begin
                  s_d.st   = ST_IDLE;
                  s_d.want = 1'b0;
                end
              end
              K_AHI:
              begin
                s_d.ptr[AW-1:8] = s_q.sh[3:0];
              end
              K_ALO:
              begin
                s_d.ptr   = lo_ptr;
                s_d.page  = lo_ptr[AW-1:5];
                s_d.vmask = '0;
              end
              K_DATA:
              begin
                s_d.pbuf[s_q.ptr[4:0]]  = s_q.sh;
                s_d.vmask[s_q.ptr[4:0]] = 1'b1;
                s_d.ptr[4:0] = s_q.ptr[4:0] + 5'h01;
                s_d.pend     = 1'b1;
              end
            endcase
          end
        end
        ST_ACK, ST_MACK:
        begin
          if (s_q.st == ST_MACK && rise && s_q.flt[I_SDA])
          begin
            s_d.st = ST_IDLE;
          end
          else if (fall)
          begin
            if (s_q.rd)
            begin
              s_d.st   = ST_TX;
              s_d.sh   = rdata;
              s_d.want = ~rdata[7];
              s_d.bits = 4'h1;
              s_d.ptr  = s_q.ptr + AW'(1);
            end
            else
            begin
              s_d.st   = ST_RX;
              s_d.want = 1'b0;
              s_d.bits = '0;
              if (s_q.kind != K_DATA)
              begin
                s_d.kind = s_q.kind + 2'h1;
              end
            end
          end
        end
        ST_TX:
        begin
          if (fall)
          begin
            if (s_q.bits == BITS_BYTE)
            begin
              s_d.st   = ST_MACK;
              s_d.want = 1'b0;
            end
            else
            begin
              s_d.sh   = {s_q.sh[6:0], 1'b0};
              s_d.want = ~s_q.sh[6];
              s_d.bits = s_q.bits + 4'h1;
            end
          end
        end
      endcase
    end

    if (fall)
    begin
      s_d.hold = HC_W'(HOLD_CYC);
    end
    else if (s_q.hold != '0)
    begin
      s_d.hold = s_q.hold - HC_W'(1);
      if (s_q.hold == HC_W'(1))
      begin
        s_d.oe = s_q.want;
      end
    end
  end

  function automatic logic [2:0] straps_raw();
    straps_raw = {chip_select_strap_2_in, chip_select_strap_1_in,
                  chip_select_strap_0_in};
  endfunction : straps_raw

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_q       <= '0;
      s_q.sy1   <= 6'h03;
      s_q.sy2   <= 6'h03;
      s_q.flt   <= 2'h3;
      s_q.flt_p <= 2'h3;
      s_q.st    <= ST_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sda_out        = 1'b0;
  assign sda_oe_out     = s_q.oe;
  assign write_busy_out = s_q.busy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_oe_hold;
    $changed(sda_oe_out) |-> $past(s_q.hold) == HC_W'(1);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("data moved early");

  property p_oe_clk_low;
    $changed(sda_oe_out) |-> !s_q.flt[I_SCL];
  endproperty
  a_oe_clk_low: assert property (p_oe_clk_low) else $error("data moved, clk high");

  property p_filter;
    $changed(s_q.flt[I_SCL]) |-> $past(s_q.fcnt[I_SCL]) == FC_W'(GF_CYC);
  endproperty
  a_filter: assert property (p_filter) else $error("spike passed filter");

  property p_ack_match;
    s_q.st == ST_ACK && s_q.kind == K_CTRL && s_q.want |-> match;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("ack on bad address");

  property p_code;
    s_q.st == ST_ACK && s_q.kind == K_CTRL |-> s_q.sh[7:4] == CTRL_CODE;
  endproperty
  a_code: assert property (p_code) else $error("wrong type code taken");

  property p_nomatch;
    s_q.st == ST_RX && s_q.kind == K_CTRL && fall && s_q.bits == BITS_BYTE
      && !match && !start && !stop |=> s_q.st == ST_IDLE;
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("no idle on mismatch");

  property p_busy_nack;
    s_q.st == ST_ACK && s_q.busy |-> !s_q.want;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("ack while busy");

  property p_wp_block;
    stop && s_q.pend && !s_q.busy && s_q.sy2[I_WP] |=> !s_q.busy [*2];
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("protected write ran");

  property p_wp_go;
    stop && s_q.pend && !s_q.busy && !s_q.sy2[I_WP] |=> s_q.busy && s_q.wc == '0;
  endproperty
  a_wp_go: assert property (p_wp_go) else $error("write did not start");

  property p_twc;
    $fell(s_q.busy) |-> $past(s_q.wc) == WC_W'(WRITE_CYCLES - 1);
  endproperty
  a_twc: assert property (p_twc) else $error("write cycle length wrong");

  property p_start;
    start |=> s_q.st == ST_RX && s_q.bits == '0 && !s_q.want;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_we_busy;
    wr.we |-> s_q.busy && s_q.wc < WC_W'(PAGE_BYTES);
  endproperty
  a_we_busy: assert property (p_we_busy) else $error("write outside cycle");

  c_start: cover property (start);
  c_read:  cover property (s_q.st == ST_ACK ##[1:1000] s_q.st == ST_TX);
  c_write: cover property ($rose(s_q.busy));
  c_nack:  cover property (s_q.st == ST_MACK ##1 s_q.st == ST_IDLE);

endmodule : sep_top
`default_nettype wire

//--- sep_master_model.sv
/*
  Two-wire bus master model: makes the bus clock, start and stop, and
  pulls the data wire low. Assumes the bench resolves the wire with a
  pull-up and feeds the level back on sda_in.
*/
`timescale 1ns/1ns
`default_nettype none
module sep_master_model
#(
  parameter int HALF = 60
)
(
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_low_out
);
  // ----------------------------------------
  // Bus idle at time zero
  // ----------------------------------------
  initial
  begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  // ----------------------------------------
  // Bus conditions and bits
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick

  task automatic start_cond();
    tick(HALF / 2);
    sda_low_out = 1'b0;
    tick(HALF / 2);
    scl_out = 1'b1;
    tick(HALF);
    sda_low_out = 1'b1;
    tick(HALF);
    scl_out = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    tick(HALF / 2);
    sda_low_out = 1'b1;
    tick(HALF / 2);
    scl_out = 1'b1;
    tick(HALF);
    sda_low_out = 1'b0;
    tick(HALF);
  endtask : stop_cond

  task automatic xbit(input logic b, input logic g, output logic r);
    tick(HALF / 2);
    sda_low_out = ~b;
    tick(HALF / 2);
    scl_out = 1'b1;
    tick(HALF / 2);
    r = sda_in;
    if (g)
    begin
      scl_out = 1'b0;
      tick(5);
      scl_out = 1'b1;
    end
    tick(HALF / 2);
    scl_out = 1'b0;
  endtask : xbit

  task automatic put_byte(input logic [7:0] d, input logic g,
                          output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], g && i == 4, r);
    xbit(1'b1, 1'b0, r);
    ack = ~r;
  endtask : put_byte

  task automatic get_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xbit(1'b1, 1'b0, r);
      d[i] = r;
    end
    xbit(~mack, 1'b0, r);
  endtask : get_byte
endmodule : sep_master_model
`default_nettype wire

//--- sep_top_test.sv
/*
  Self-checking bench of the EEPROM pin slave: address match table, then
  write, busy, protect and read-back cases. Assumes the master model file.
*/
`timescale 1ns/1ns
`default_nettype none
module sep_top_test;
  localparam int W = 5000;
  typedef struct packed {
    logic [2:0] cs;
    logic [7:0] ctrl;
    logic       ack;
  } sep_row_s;

  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic [2:0] cs     = 3'h0;
  logic       wp     = 1'b0;
  logic       scl;
  logic       m_low;
  logic       wire_sda;
  logic       sda_out;
  logic       sda_oe;
  logic       busy;
  logic       oe_prev = 1'b0;
  logic       a;
  int         n_mismatch = 0;
  int         num_checks = 0;
  int         low_cnt = 0;
  int         busy_cnt = 0;
  int         busy_len = 0;
  sep_row_s   rows [7] = '{'{3'h0, 8'ha0, 1'b1}, '{3'h5, 8'haa, 1'b1},
                           '{3'h5, 8'ha8, 1'b0}, '{3'h3, 8'hb6, 1'b0},
                           '{3'h2, 8'h24, 1'b0}, '{3'h6, 8'hac, 1'b1},
                           '{3'h1, 8'ha4, 1'b0}};

  always #5 clk_in = ~clk_in;
  assign wire_sda = (sda_oe ? sda_out : 1'b1) & ~m_low;

  sep_top #(.WRITE_CYCLES(W)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(wire_sda),
    .chip_select_strap_0_in(cs[0]), .chip_select_strap_1_in(cs[1]),
    .chip_select_strap_2_in(cs[2]), .write_protect_in(wp),
    .sda_out(sda_out), .sda_oe_out(sda_oe), .write_busy_out(busy));
  sep_master_model #(.HALF(60)) u_mst (
    .clk_in(clk_in), .sda_in(wire_sda), .scl_out(scl),
    .sda_low_out(m_low));

  // ----------------------------------------
  // Compare and verdict
  // ----------------------------------------
  task automatic chk_bit(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit

  task automatic chk_val(input string n, input logic [31:0] e,
                         input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk_val

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Wire monitor and busy length
  // ----------------------------------------
  always @(negedge clk_in)
  begin
    low_cnt = scl ? 0 : low_cnt + 1;
    if (busy === 1'b1)
      busy_cnt++;
    else if (busy_cnt != 0)
    begin
      busy_len = busy_cnt;
      busy_cnt = 0;
    end
    if (!rst_in && sda_oe !== oe_prev)
    begin
      chk_bit("oe_moves_scl_low", 1'b0, scl);
      chk_bit("oe_hold_300ns", 1'b1, low_cnt >= 30);
    end
    if (sda_oe === 1'b1)
      chk_bit("sda_drive_low_only", 1'b0, sda_out);
    oe_prev = sda_oe;
  end

  // ----------------------------------------
  // Transfers
  // ----------------------------------------
  task automatic do_write(input logic [15:0] ad, input logic [15:0] dt,
                          input logic g, input logic wp_stop);
    logic [31:0] b;
    b = {ad, dt};
    u_mst.start_cond();
    u_mst.put_byte(8'ha0, g, a);
    chk_bit("ack_ctrl_wr", 1'b1, a);
    for (int i = 3; i >= 0; i--)
    begin
      u_mst.put_byte(b[8*i +: 8], 1'b0, a);
      chk_bit("ack_wr_byte", 1'b1, a);
    end
    wp = wp_stop;
    u_mst.stop_cond();
  endtask : do_write

  task automatic do_read(input logic [15:0] ad, input logic [15:0] ex);
    logic [7:0] d;
    u_mst.start_cond();
    u_mst.put_byte(8'ha0, 1'b0, a);
    u_mst.put_byte(ad[15:8], 1'b0, a);
    u_mst.put_byte(ad[7:0], 1'b0, a);
    u_mst.start_cond();
    u_mst.put_byte(8'ha1, 1'b0, a);
    chk_bit("ack_ctrl_rd", 1'b1, a);
    u_mst.get_byte(1'b1, d);
    chk_val("rd_byte0", ex[15:8], d);
    u_mst.get_byte(1'b0, d);
    chk_val("rd_byte1", ex[7:0], d);
    u_mst.stop_cond();
  endtask : do_read

  task automatic wait_idle();
    for (int k = 0; k < 2 * W && busy !== 1'b0; k++)
      @(negedge clk_in);
    u_mst.tick(2);
  endtask : wait_idle

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    u_mst.tick(10);
    chk_bit("oe_reset", 1'b0, sda_oe);
    chk_bit("busy_reset", 1'b0, busy);
    foreach (rows[i])
    begin
      cs = rows[i].cs;
      u_mst.start_cond();
      u_mst.put_byte(rows[i].ctrl, 1'b0, a);
      chk_bit("ack_addr_match", rows[i].ack, a);
      u_mst.stop_cond();
    end
    cs = 3'h0;
    do_write(16'h0123, 16'h5a5b, 1'b1, 1'b0);
    chk_bit("busy_after_stop", 1'b1, busy);
    u_mst.start_cond();
    u_mst.put_byte(8'ha0, 1'b0, a);
    chk_bit("ack_while_busy", 1'b0, a);
    u_mst.stop_cond();
    wait_idle();
    chk_val("busy_len", W, busy_len);
    do_read(16'h0123, 16'h5a5b);
    wp = 1'b1;
    do_write(16'h0123, 16'hc3c4, 1'b0, 1'b1);
    u_mst.tick(20);
    chk_bit("busy_blocked", 1'b0, busy);
    do_read(16'h0123, 16'h5a5b);
    do_write(16'h0125, 16'h7700, 1'b0, 1'b0);
    chk_bit("busy_wp_low_at_stop", 1'b1, busy);
    wait_idle();
    do_read(16'h0125, 16'h7700);
    print_verdict();
  end

  initial
  begin
    #800000;
    n_mismatch++;
    print_verdict();
  end
endmodule : sep_top_test
`default_nettype wire
